/* File: mem_strobe_model.sv */
// memory side model: free running edge clock and read strobe bursts
`timescale 1ns/100ps
module mem_strobe_model (
  input wire logic go,
  input wire logic [3:0] edges,
  output logic strobe,
  output logic edge_clk
);
  // odd start offset keeps the edge clock transitions just off the system clock edges, at a fixed phase
  initial begin
    edge_clk = 1'b0;
    #37;
    forever #100 edge_clk = ~edge_clk;
  end
  // strobe rests low between bursts so no stale edge is ever seen
  initial strobe = 1'b0;
  always @(posedge go) begin
    #13;
    for (int i = 0; i < edges; i++) begin
      #100 strobe = 1'b1;
      #100 strobe = 1'b0;
    end
  end
endmodule

/* File: pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);
  logic s1_ff, s2_ff, s3_ff, val_ff;
  logic nxt_val;
  // the first stage feeds only the second
  always_comb begin
    nxt_val = (s2_ff == s3_ff) ? s3_ff : val_ff;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      val_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      val_ff <= nxt_val;
    end
  end
  assign dout = val_ff;
endmodule

/* File: slave_delay_line.sv */
// tapped slave delay line with margin offset
`timescale 1ns/100ps
module slave_delay_line (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  input wire logic [strobe_delay_pkg::CODE_W-1:0] base_code,
  input wire strobe_delay_pkg::margin_type margin,
  output logic dout,
  output logic limit
);
  import strobe_delay_pkg::*;
  localparam logic signed [10:0] TAP_MAX = 11'(TAPS - 1);
  logic [TAPS-1:0] line_ff, nxt_line;
  logic signed [CODE_W-1:0] off_ff, nxt_off;
  logic dout_ff, nxt_dout;
  logic signed [10:0] sum;
  logic [4:0] tap;
  logic lo_lim, hi_lim;
  always_comb begin
    sum = $signed({2'b00, base_code}) + 11'(off_ff);
    lo_lim = (sum <= 11'sd0);
    hi_lim = (sum >= TAP_MAX);
    tap = lo_lim ? 5'h00 : (hi_lim ? 5'(TAP_MAX) : sum[4:0]);
    nxt_line = {line_ff[TAPS-2:0], din};
    nxt_dout = line_ff[tap];
    nxt_off = off_ff;
    if (!margin.load_n) begin
      nxt_off = '0;
    end else if (margin.step && margin.dir && !hi_lim) begin
      nxt_off = off_ff + 9'sd1;
    end else if (margin.step && !margin.dir && !lo_lim) begin
      nxt_off = off_ff - 9'sd1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_ff <= '0;
      off_ff <= '0;
      dout_ff <= 1'b0;
    end else begin
      line_ff <= nxt_line;
      off_ff <= nxt_off;
      dout_ff <= nxt_dout;
    end
  end
  assign dout = dout_ff;
  assign limit = hi_lim | (lo_lim & (off_ff != '0));
  property p_load_clears;
    @(posedge aclk) disable iff (!aresetn) !margin.load_n |=> off_ff == '0;
  endproperty
  a_load_clears: assert property (p_load_clears) else $error("offset not cleared by load");
  property p_step_up;
    @(posedge aclk) disable iff (!aresetn)
      margin.load_n && margin.step && margin.dir && !hi_lim |=> off_ff == $past(off_ff) + 9'sd1;
  endproperty
  a_step_up: assert property (p_step_up) else $error("offset did not step up");
endmodule

/* File: strobe_delay_block.sv */
// strobe delay, write clock and capture fifo pointer block with axi4-lite registers
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module strobe_delay_block (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [strobe_delay_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [strobe_delay_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic strobe_in,
  input wire logic fast_edge_clock,
  output logic read_capture_strobe,
  output logic write_data_clock,
  output logic write_strobe_clock,
  output logic [strobe_delay_pkg::PTR_W-1:0] fifo_rd_pointer,
  output logic [strobe_delay_pkg::PTR_W-1:0] fifo_wr_pointer,
  output logic valid_start_flag,
  output logic burst_seen_flag,
  output logic rd_delay_count,
  output logic wr_delay_count,
  output logic [strobe_delay_pkg::CODE_W-1:0] delay_code_out
);
  import strobe_delay_pkg::*;
  logic strobe_s, edge_s, edge_prev_ff, edge_rise;
  logic rd_dout, wr_dout, lvl_dout, rd_lim, wr_lim, lvl_lim;
  margin_type rd_margin, wr_margin, lvl_margin;
  logic [CODE_W-1:0] code_used;
  // axi and register state
  logic awready_ff, nxt_awready, wready_ff, nxt_wready, bvalid_ff, nxt_bvalid;
  logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata, wdata_ff, nxt_wdata, ctrl_ff, nxt_ctrl;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [CODE_W-1:0] code_in_ff, nxt_code_in;
  logic [2:0] step_ff, nxt_step;
  logic arm_ff, nxt_arm, burst_clr;
  // lock loop state
  dll_state_type dll_ff, nxt_dll;
  logic [CODE_W-1:0] cnt_ff, nxt_cnt, per_ff, nxt_per, period;
  // read window state
  win_state_type win_ff, nxt_win;
  logic [3:0] left_ff, nxt_left, ecnt_ff, nxt_ecnt;
  logic started_ff, nxt_started, cap_prev_ff, cap_rise;
  logic [PTR_W-1:0] wrp_ff, nxt_wrp, rdp_ff, nxt_rdp;
  logic valid_ff, nxt_valid, burst_ff, nxt_burst, burst_set;
  logic rdc_ff, wrc_ff;
  logic [CODE_W-1:0] code_o_ff;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  pin_sync u_sync_strobe (.aclk(aclk), .aresetn(aresetn), .din(strobe_in), .dout(strobe_s));
  pin_sync u_sync_edge (.aclk(aclk), .aresetn(aresetn), .din(fast_edge_clock), .dout(edge_s));
  assign edge_rise = edge_s & ~edge_prev_ff;

  // direct code overrides the loop code when selected
  assign code_used = ctrl_ff[DIRECT_BIT] ? code_in_ff : per_ff >> 2;
  assign rd_margin = '{load_n: ctrl_ff[RD_LOAD_BIT], step: step_ff[STEP_RD_BIT],
                       dir: ctrl_ff[RD_DIR_BIT]};
  assign wr_margin = '{load_n: ctrl_ff[WR_LOAD_BIT], step: step_ff[STEP_WR_BIT],
                       dir: ctrl_ff[WR_DIR_BIT]};
  assign lvl_margin = '{load_n: ctrl_ff[LVL_LOAD_BIT], step: step_ff[STEP_LVL_BIT],
                        dir: ctrl_ff[LVL_DIR_BIT]};

  slave_delay_line u_rd_line (.aclk(aclk), .aresetn(aresetn), .din(strobe_s),
    .base_code(code_used), .margin(rd_margin), .dout(rd_dout), .limit(rd_lim));
  slave_delay_line u_wr_line (.aclk(aclk), .aresetn(aresetn), .din(edge_s),
    .base_code(code_used), .margin(wr_margin), .dout(wr_dout), .limit(wr_lim));
  // leveling starts at zero delay and moves only by its own margin controls
  slave_delay_line u_lvl_line (.aclk(aclk), .aresetn(aresetn), .din(edge_s),
    .base_code(CODE_RESET), .margin(lvl_margin), .dout(lvl_dout), .limit(lvl_lim));

  always_comb begin
    nxt_awready = awready_ff;
    nxt_wready = wready_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_arready = arready_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_ctrl = ctrl_ff;
    nxt_code_in = code_in_ff;
    nxt_step = 3'h0;
    nxt_arm = 1'b0;
    burst_clr = 1'b0;
    if (s_axi_awvalid && awready_ff) begin
      nxt_awready = 1'b0;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_wready = 1'b0;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (!awready_ff && !wready_ff && !bvalid_ff) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      unique case (awaddr_ff)
        CTRL_OFS: begin
          nxt_ctrl = merge(ctrl_ff, wdata_ff, wstrb_ff) & CTRL_MASK;
          nxt_arm = wstrb_ff[1] && (wdata_ff[REQ_LSB +: 2] != 2'h0);
        end
        STEP_OFS: nxt_step = wstrb_ff[0] ? wdata_ff[2:0] : 3'h0;
        CODE_OFS: nxt_code_in = CODE_W'(merge({23'h0, code_in_ff}, wdata_ff, wstrb_ff));
        STAT_OFS: burst_clr = wstrb_ff[1] && wdata_ff[ST_BURST_BIT];
        default: nxt_bresp = RESP_DECERR;
      endcase
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
      nxt_awready = 1'b1;
      nxt_wready = 1'b1;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        CTRL_OFS: nxt_rdata = ctrl_ff;
        STEP_OFS: nxt_rdata = 32'h0000_0000;
        CODE_OFS: nxt_rdata = {23'h0, code_in_ff};
        STAT_OFS: nxt_rdata = {10'h0, started_ff, win_ff, rdp_ff, wrp_ff, lvl_lim, wrc_ff,
                               rdc_ff, burst_ff, (dll_ff == DLL_LOCKED), code_o_ff};
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = RESP_DECERR;
        end
      endcase
    end
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
      nxt_arready = 1'b1;
    end
  end

  // loop measures the edge clock period in system cycles and locks on two equal periods
  always_comb begin
    nxt_dll = dll_ff;
    nxt_cnt = cnt_ff + 9'h001;
    nxt_per = per_ff;
    period = cnt_ff + 9'h001;
    unique case (dll_ff)
      DLL_WAIT: if (edge_rise) begin
        nxt_dll = DLL_MEASURE;
        nxt_cnt = 9'h000;
      end
      DLL_MEASURE, DLL_LOCKED: if (edge_rise) begin
        nxt_cnt = 9'h000;
        nxt_per = period;
        nxt_dll = (period == per_ff) ? DLL_LOCKED : DLL_MEASURE;
      end
      default: nxt_dll = DLL_WAIT;
    endcase
  end

  assign cap_rise = rd_dout & ~cap_prev_ff;
  always_comb begin
    nxt_win = win_ff;
    nxt_left = left_ff;
    nxt_ecnt = ecnt_ff;
    nxt_started = started_ff;
    nxt_wrp = wrp_ff;
    nxt_rdp = rdp_ff;
    nxt_valid = 1'b0;
    burst_set = 1'b0;
    unique case (win_ff)
      WIN_IDLE: if (arm_ff) begin
        nxt_win = WIN_OPEN;
        nxt_left = {2'b00, ctrl_ff[REQ_LSB +: 2]} * BURST_EDGES;
        nxt_ecnt = 4'h0;
        nxt_started = 1'b0;
      end
      WIN_OPEN: if (cap_rise) begin
        nxt_wrp = wrp_ff + 3'h1;
        nxt_ecnt = ecnt_ff + 4'h1;
        nxt_left = left_ff - 4'h1;
        if (ecnt_ff == {1'b0, ctrl_ff[SEL_LSB +: 3]}) begin
          nxt_valid = 1'b1;
          nxt_started = 1'b1;
        end
        burst_set = (ecnt_ff == BURST_EDGES - 4'h1);
        if (left_ff == 4'h1) begin
          nxt_win = WIN_IDLE;
        end
      end
    endcase
    // drain side follows the edge clock and never passes the fill side
    if (edge_rise && started_ff && rdp_ff != wrp_ff) begin
      nxt_rdp = rdp_ff + 3'h1;
    end
    nxt_burst = burst_set | (burst_ff & ~burst_clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      ctrl_ff <= CTRL_RESET;
      code_in_ff <= CODE_RESET;
      step_ff <= 3'h0;
      arm_ff <= 1'b0;
      dll_ff <= DLL_WAIT;
      cnt_ff <= 9'h000;
      per_ff <= 9'h000;
      edge_prev_ff <= 1'b0;
      win_ff <= WIN_IDLE;
      left_ff <= 4'h0;
      ecnt_ff <= 4'h0;
      started_ff <= 1'b0;
      cap_prev_ff <= 1'b0;
      wrp_ff <= 3'h0;
      rdp_ff <= 3'h0;
      valid_ff <= 1'b0;
      burst_ff <= 1'b0;
      rdc_ff <= 1'b0;
      wrc_ff <= 1'b0;
      code_o_ff <= CODE_RESET;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      ctrl_ff <= nxt_ctrl;
      code_in_ff <= nxt_code_in;
      step_ff <= nxt_step;
      arm_ff <= nxt_arm;
      dll_ff <= nxt_dll;
      cnt_ff <= nxt_cnt;
      per_ff <= nxt_per;
      edge_prev_ff <= edge_s;
      win_ff <= nxt_win;
      left_ff <= nxt_left;
      ecnt_ff <= nxt_ecnt;
      started_ff <= nxt_started;
      cap_prev_ff <= rd_dout;
      wrp_ff <= nxt_wrp;
      rdp_ff <= nxt_rdp;
      valid_ff <= nxt_valid;
      burst_ff <= nxt_burst;
      rdc_ff <= rd_lim;
      wrc_ff <= wr_lim;
      code_o_ff <= code_used;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign read_capture_strobe = rd_dout;
  assign write_data_clock = wr_dout;
  assign write_strobe_clock = lvl_dout;
  assign fifo_rd_pointer = rdp_ff;
  assign fifo_wr_pointer = wrp_ff;
  assign valid_start_flag = valid_ff;
  assign burst_seen_flag = burst_ff;
  assign rd_delay_count = rdc_ff;
  assign wr_delay_count = wrc_ff;
  assign delay_code_out = code_o_ff;

  sequence s_two_equal;
    (dll_ff != DLL_WAIT) && edge_rise && (period == per_ff);
  endsequence
  property p_dll_lock;
    @(posedge aclk) disable iff (!aresetn) s_two_equal |=> dll_ff == DLL_LOCKED;
  endproperty
  a_dll_lock: assert property (p_dll_lock) else $error("loop did not lock");
  property p_wr_ptr_step;
    @(posedge aclk) disable iff (!aresetn)
      $changed(wrp_ff) |-> wrp_ff == $past(wrp_ff) + 3'h1 && $past(win_ff) == WIN_OPEN;
  endproperty
  a_wr_ptr_step: assert property (p_wr_ptr_step) else $error("write pointer bad step");
  property p_rd_behind;
    @(posedge aclk) disable iff (!aresetn) $changed(rdp_ff) |-> $past(rdp_ff) != $past(wrp_ff);
  endproperty
  a_rd_behind: assert property (p_rd_behind) else $error("read pointer passed write");
  sequence s_arm;
    arm_ff && win_ff == WIN_IDLE;
  endsequence
  property p_arm_window;
    @(posedge aclk) disable iff (!aresetn) s_arm |=> win_ff == WIN_OPEN && ecnt_ff == 4'h0;
  endproperty
  a_arm_window: assert property (p_arm_window) else $error("window not opened");
  property p_valid_pulse;
    @(posedge aclk) disable iff (!aresetn)
      valid_start_flag |-> $past(cap_rise) && started_ff ##1 !valid_start_flag;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid start not a pulse");
  property p_burst_sticky;
    @(posedge aclk) disable iff (!aresetn) burst_ff && !burst_clr |=> burst_ff;
  endproperty
  a_burst_sticky: assert property (p_burst_sticky) else $error("burst flag lost");
  property p_code_out;
    @(posedge aclk) disable iff (!aresetn)
      ctrl_ff[DIRECT_BIT] && $stable(code_in_ff) |=> delay_code_out == $past(code_in_ff);
  endproperty
  a_code_out: assert property (p_code_out) else $error("direct code not reported");
  property p_bresp_hold;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
endmodule

/* File: strobe_delay_pkg.sv */
// shared constants, types and register map of the strobe delay block
package strobe_delay_pkg;
  localparam int ADDR_W = 8;
  localparam int CODE_W = 9;
  localparam int PTR_W = 3;
  localparam int TAPS = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STEP_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] CODE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h0C;
  localparam int DIRECT_BIT = 0;
  localparam int RD_LOAD_BIT = 1;
  localparam int RD_DIR_BIT = 2;
  localparam int WR_LOAD_BIT = 3;
  localparam int WR_DIR_BIT = 4;
  localparam int LVL_LOAD_BIT = 5;
  localparam int LVL_DIR_BIT = 6;
  localparam int REQ_LSB = 8;
  localparam int SEL_LSB = 10;
  localparam int STEP_RD_BIT = 0;
  localparam int STEP_WR_BIT = 1;
  localparam int STEP_LVL_BIT = 2;
  localparam int ST_LOCK_BIT = 9;
  localparam int ST_BURST_BIT = 10;
  localparam logic [31:0] CTRL_MASK = 32'h0000_1F7F;
  localparam logic [31:0] CTRL_RESET = 32'h0000_002A;
  localparam logic [CODE_W-1:0] CODE_RESET = 9'h000;
  localparam logic [3:0] BURST_EDGES = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef struct packed {
    logic load_n;
    logic step;
    logic dir;
  } margin_type;
  typedef enum logic [1:0] {
    DLL_WAIT = 2'b00,
    DLL_MEASURE = 2'b01,
    DLL_LOCKED = 2'b10
  } dll_state_type;
  typedef enum logic {
    WIN_IDLE = 1'b0,
    WIN_OPEN = 1'b1
  } win_state_type;
endpackage

/* File: tb_strobe_delay_block.sv */
// self-checking bench for the strobe delay block
`timescale 1ns/100ps
module tb_strobe_delay_block;
  import strobe_delay_pkg::*;
  // edge clock period in system cycles, a quarter of it gives ninety degrees
  localparam int LOOP_CODE = (200 / 25) / 4;
  localparam int STEPS = TAPS + 8;
  logic aclk, aresetn, go, rcs_q, wd_q, ws_q;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdata_v;
  logic [3:0] s_axi_wstrb, edges;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_v;
  logic strobe_in, fast_edge_clock, read_capture_strobe, write_data_clock, write_strobe_clock;
  logic valid_start_flag, burst_seen_flag, rd_delay_count, wr_delay_count;
  logic [PTR_W-1:0] fifo_rd_pointer, fifo_wr_pointer;
  logic [CODE_W-1:0] delay_code_out;
  int err_count, checks_done, seed, ctrl_ref, code_ref, wr_ref, lim, n, sel;
  int rcs_rises, vs_pulses, wd_rises, ws_rises;

  strobe_delay_block uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .strobe_in(strobe_in), .fast_edge_clock(fast_edge_clock),
    .read_capture_strobe(read_capture_strobe), .write_data_clock(write_data_clock),
    .write_strobe_clock(write_strobe_clock), .fifo_rd_pointer(fifo_rd_pointer),
    .fifo_wr_pointer(fifo_wr_pointer), .valid_start_flag(valid_start_flag),
    .burst_seen_flag(burst_seen_flag), .rd_delay_count(rd_delay_count),
    .wr_delay_count(wr_delay_count), .delay_code_out(delay_code_out));

  mem_strobe_model partner (.go(go), .edges(edges), .strobe(strobe_in),
    .edge_clk(fast_edge_clock));

  always #12.5 aclk = ~aclk;

  // edge and pulse counters seen from the system clock
  always @(posedge aclk) begin
    rcs_q <= read_capture_strobe;
    wd_q <= write_data_clock;
    ws_q <= write_strobe_clock;
    if (read_capture_strobe === 1'b1 && rcs_q === 1'b0) rcs_rises++;
    if (write_data_clock === 1'b1 && wd_q === 1'b0) wd_rises++;
    if (write_strobe_clock === 1'b1 && ws_q === 1'b0) ws_rises++;
    if (valid_start_flag === 1'b1) vs_pulses++;
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task stop_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    logic aw_ok, w_ok, b_ok;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    k = 0;
    while (!b_ok && k < 200) begin
      @(posedge aclk);
      k++;
      if (!aw_ok && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_ok = 1'b1;
      end
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        b_ok = 1'b1;
      end
    end
    if (!b_ok) err_count++;
  endtask

  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    logic a_ok, r_ok;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    a_ok = 1'b0;
    r_ok = 1'b0;
    k = 0;
    while (!r_ok && k < 200) begin
      @(posedge aclk);
      k++;
      if (!a_ok && s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
        a_ok = 1'b1;
      end
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        r_ok = 1'b1;
      end
    end
    if (!r_ok) err_count++;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, resp_v);
    check("write response", 32'(resp_v), 32'(RESP_OKAY));
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp,
      input string name);
    axi_rd(a, rdata_v, resp_v);
    check(name, rdata_v & mask, exp);
  endtask

  // arms a read window, then lets the memory send e strobe edges
  task window(input int req, input int sl, input int e);
    int k;
    rcs_rises = 0;
    vs_pulses = 0;
    wr(CTRL_OFS, ctrl_ref | (req << REQ_LSB) | (sl << SEL_LSB));
    @(posedge aclk);
    edges <= 4'(e);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    k = 0;
    while (rcs_rises < e && k < 400) begin
      @(posedge aclk);
      k++;
    end
    repeat (8) @(posedge aclk);
    wr_ref = (wr_ref + 4 * req) % 8;
  endtask

  initial begin
    #1_000_000;
    err_count++;
    stop_test;
  end

  initial begin
    {aclk, aresetn, go, edges, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    {err_count, checks_done, wr_ref, rcs_rises, vs_pulses, wd_rises, ws_rises} = '0;
    seed = 85636;
    ctrl_ref = 32'h0000_002A;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_002A, "ctrl reset");
    rd_chk(CODE_OFS, 32'hFFFF_FFFF, 32'h0000_0000, "code reset");
    n = 0;
    do begin
      axi_rd(STAT_OFS, rdata_v, resp_v);
      n++;
    end while (rdata_v[ST_LOCK_BIT] !== 1'b1 && n < 100);
    check("lock", 32'(rdata_v[ST_LOCK_BIT]), 32'h1);
    check("loop code", 32'(delay_code_out), LOOP_CODE);
    rd_chk(STAT_OFS, 32'h1FF, LOOP_CODE, "status code");
    axi_wr(8'h10, 32'h0000_0001, resp_v);
    check("unmapped write", 32'(resp_v), 32'(RESP_DECERR));
    axi_rd(8'h14, rdata_v, resp_v);
    check("unmapped read", 32'(resp_v), 32'(RESP_DECERR));
    code_ref = $random(seed) & 32'h1FF;
    wr(CODE_OFS, code_ref);
    wr(CTRL_OFS, ctrl_ref | 1);
    repeat (2) @(posedge aclk);
    check("direct code", 32'(delay_code_out), code_ref);
    rd_chk(CODE_OFS, 32'h1FF, code_ref, "code readback");
    wr(CTRL_OFS, ctrl_ref);
    repeat (2) @(posedge aclk);
    check("loop code again", 32'(delay_code_out), LOOP_CODE);
    // each line is driven to its upper limit while the others stay put
    lim = 0;
    for (int i = 0; i < 3; i++) begin
      wr(CTRL_OFS, ctrl_ref | (1 << (RD_DIR_BIT + 2 * i)));
      repeat (STEPS) wr(STEP_OFS, 1 << i);
      lim = lim | (1 << i);
      rd_chk(STAT_OFS, 32'h7 << 11, lim << 11, "limit flags");
    end
    check("rd count", 32'(rd_delay_count), 32'h1);
    check("wr count", 32'(wr_delay_count), 32'h1);
    // loads held low clear the offsets and swallow steps
    wr(CTRL_OFS, 32'h0000_0054);
    repeat (STEPS) wr(STEP_OFS, 32'h7);
    check("rd count cleared", 32'(rd_delay_count), 32'h0);
    check("wr count cleared", 32'(wr_delay_count), 32'h0);
    wr(CTRL_OFS, ctrl_ref);
    wd_rises = 0;
    ws_rises = 0;
    repeat (160) @(posedge aclk);
    check("data clock", 32'(wd_rises >= 19 && wd_rises <= 21), 32'h1);
    check("strobe clock", 32'(ws_rises >= 19 && ws_rises <= 21), 32'h1);
    sel = $random(seed) & 3;
    window(1, sel, 4);
    check("capture edges", 32'(rcs_rises), 32'h4);
    check("valid pulses", 32'(vs_pulses), 32'h1);
    check("wr pointer", 32'(fifo_wr_pointer), wr_ref);
    check("burst seen", 32'(burst_seen_flag), 32'h1);
    repeat (60) @(posedge aclk);
    check("rd pointer", 32'(fifo_rd_pointer), wr_ref);
    rd_chk(STAT_OFS, 32'h7 << 14, wr_ref << 14, "status wr pointer");
    wr(STAT_OFS, 1 << ST_BURST_BIT);
    check("burst cleared", 32'(burst_seen_flag), 32'h0);
    // extra edges beyond the window and a select past its end
    window(1, 4 + ($random(seed) & 3), 6);
    check("capture edges long", 32'(rcs_rises), 32'h6);
    check("no valid pulse", 32'(vs_pulses), 32'h0);
    check("wr pointer framed", 32'(fifo_wr_pointer), wr_ref);
    check("burst seen again", 32'(burst_seen_flag), 32'h1);
    stop_test;
  end
endmodule
